// ---- logic/siem_pkg.sv ----
// shared constants, types and tables for the smbus expander manager
package siem_pkg;

	// ******************************
	// sizes and timing
	// ******************************
	localparam int NUM_EXP = 5;
	localparam int ADDR_W = 7;
	localparam int EXP_W = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int UPDATE_PERIOD_MS = 40;
	localparam int NS_PER_MS = 1000000;
	localparam int UPDATE_CYCLES = UPDATE_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int SMB_PERIOD_NS = 10000;
	localparam int SMB_QTR_CYCLES = SMB_PERIOD_NS / CLK_PERIOD_NS / 4;

	// ******************************
	// expander numbering and layout
	// ******************************
	localparam int EXP_PWRGOOD = 2;
	localparam int EXP_LED = 4;
	// direction register: 1 = input
	localparam logic [15:0] HP_DIR = 16'h0F0F;
	localparam logic [15:0] PWRGOOD_DIR = 16'hFF0F;
	localparam logic [15:0] LED_DIR = 16'h0000;
	localparam logic [15:0] HP_OUT_MASK = 16'hF0F0;
	localparam logic [15:0] PWRGOOD_OUT_MASK = 16'h00F0;
	localparam logic [15:0] LED_OUT_MASK = 16'hFFFF;
	localparam logic [7:0] NO_INVERT = 8'h00;

	// ******************************
	// job step masks; step n addresses expander register (n + 2) mod 8
	// ******************************
	localparam logic [2:0] REG_OFFSET = 3'h2;
	localparam logic [2:0] STEP_FIRST_READ = 3'h6;
	localparam logic [2:0] STEP_LAST = 3'h7;
	localparam logic [7:0] JOB_CFG = 8'hFF;
	localparam logic [7:0] JOB_CFG_NO_UPPER_DEF = 8'hFD;
	localparam logic [7:0] JOB_UPDATE = 8'h03;
	localparam logic [7:0] JOB_READ = 8'hC0;
	localparam logic [7:0] JOB_RELOAD = 8'hC3;
	localparam logic [7:0] JOB_NONE = 8'h00;

	typedef struct packed {
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0] cmd;
		logic [7:0] wdata;
	} siem_req_t;

	typedef struct packed {
		logic [2:0] sel;
		logic test_mode;
		logic reload;
		logic wr;
		logic [15:0] wdata;
	} siem_debug_t;

	typedef struct packed {
		logic lost_arb;
		logic nack;
	} siem_status_t;

	typedef enum {M_IDLE, M_START, M_BIT, M_STOP} siem_bus_state_t;
	typedef enum {J_IDLE, J_ISSUE, J_WAIT} siem_job_state_t;

	function automatic logic [15:0] dir_of(input int e);
		if (e == EXP_PWRGOOD) return PWRGOOD_DIR;
		if (e == EXP_LED) return LED_DIR;
		return HP_DIR;
	endfunction

	function automatic logic [15:0] out_mask_of(input int e);
		if (e == EXP_PWRGOOD) return PWRGOOD_OUT_MASK;
		if (e == EXP_LED) return LED_OUT_MASK;
		return HP_OUT_MASK;
	endfunction

endpackage

// ---- logic/siem_smb_master.sv ----
// single-byte smbus master: register write or register read with restart
`timescale 1ns/1ps
module siem_smb_master #(
	parameter int QTR_CYCLES = siem_pkg::SMB_QTR_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire siem_pkg::siem_req_t req_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic done_o,
	output logic nack_o,
	output logic lost_o,
	output logic [7:0] rdata_o,
	output logic scl_o,
	output logic scl_oe_n_o,
	output logic sda_o,
	output logic sda_oe_n_o
);
	localparam int QW = $clog2(QTR_CYCLES + 1);

	// ******************************
	// pin synchronisers and quarter-bit tick
	// ******************************
	logic scl_meta, scl_sync, sda_meta, sda_sync;
	logic [QW-1:0] qcnt;
	wire tick = (qcnt == '0);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			qcnt <= '0;
		end else begin
			scl_meta <= scl_i;
			scl_sync <= scl_meta;
			sda_meta <= sda_i;
			sda_sync <= sda_meta;
			qcnt <= tick ? QW'(QTR_CYCLES - 1) : qcnt - 1'b1;
		end
	end

	// ******************************
	// byte framing
	// ******************************
	siem_pkg::siem_bus_state_t state;
	siem_pkg::siem_req_t req_q;
	logic [1:0] ph;
	logic [3:0] bitn;
	logic [1:0] bytn;
	logic [7:0] sh;

	wire rx_byte = req_q.rd && (bytn == 2'h3);
	wire last_byte = req_q.rd ? (bytn == 2'h3) : (bytn == 2'h2);
	wire restart_next = req_q.rd && (bytn == 2'h1);
	wire data_bit = (bitn < 4'h8);
	wire drive_low = data_bit && !rx_byte && !sh[7];
	wire [1:0] next_bytn = bytn + 2'h1;
	// address, command, then data or read address
	wire [7:0] next_byte = (next_bytn == 2'h1) ? req_q.cmd :
		req_q.rd ? {req_q.addr, 1'b1} : req_q.wdata;
	wire [7:0] first_byte = (bytn == 2'h0) ? {req_q.addr, 1'b0} : {req_q.addr, 1'b1};

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= siem_pkg::M_IDLE;
			req_q <= '0;
			ph <= 2'h0;
			bitn <= 4'h0;
			bytn <= 2'h0;
			sh <= 8'h00;
			done_o <= 1'b0;
			nack_o <= 1'b0;
			lost_o <= 1'b0;
			rdata_o <= 8'h00;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_n_o <= 1'b1;
			sda_oe_n_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			case (state)
				siem_pkg::M_IDLE: if (req_valid_i) begin
					req_q <= req_i;
					bytn <= 2'h0;
					ph <= 2'h0;
					nack_o <= 1'b0;
					lost_o <= 1'b0;
					state <= siem_pkg::M_START;
				end
				siem_pkg::M_START: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: sda_oe_n_o <= 1'b1;
						2'h1: scl_oe_n_o <= 1'b1;
						2'h2: sda_oe_n_o <= 1'b0;
						default: begin
							scl_oe_n_o <= 1'b0;
							bitn <= 4'h0;
							sh <= first_byte;
							state <= siem_pkg::M_BIT;
						end
					endcase
				end
				siem_pkg::M_BIT: if (tick) begin
					case (ph)
						2'h0: begin
							sda_oe_n_o <= !drive_low;
							ph <= 2'h1;
						end
						2'h1: begin
							scl_oe_n_o <= 1'b1;
							ph <= 2'h2;
						end
						// waits here while a slave stretches the clock
						2'h2: if (scl_sync) begin
							ph <= 2'h3;
							if (data_bit && rx_byte)
								sh <= {sh[6:0], sda_sync};
							else if (data_bit && sh[7] && !sda_sync)
								lost_o <= 1'b1;
							else if (!data_bit && !rx_byte)
								nack_o <= sda_sync;
						end
						default: begin
							scl_oe_n_o <= 1'b0;
							ph <= 2'h0;
							if (lost_o) begin
								// another master owns the bus: let go of both lines
								scl_oe_n_o <= 1'b1;
								sda_oe_n_o <= 1'b1;
								done_o <= 1'b1;
								state <= siem_pkg::M_IDLE;
							end else if (data_bit) begin
								bitn <= bitn + 4'h1;
								if (!rx_byte)
									sh <= {sh[6:0], 1'b0};
							end else begin
								if (rx_byte)
									rdata_o <= sh;
								if (nack_o || last_byte) begin
									state <= siem_pkg::M_STOP;
								end else if (restart_next) begin
									bytn <= next_bytn;
									state <= siem_pkg::M_START;
								end else begin
									bytn <= next_bytn;
									bitn <= 4'h0;
									sh <= next_byte;
								end
							end
						end
					endcase
				end
				siem_pkg::M_STOP: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: sda_oe_n_o <= 1'b0;
						2'h1: scl_oe_n_o <= 1'b1;
						2'h2: sda_oe_n_o <= 1'b1;
						default: begin
							done_o <= 1'b1;
							state <= siem_pkg::M_IDLE;
						end
					endcase
				end
				default: state <= siem_pkg::M_IDLE;
			endcase
		end
	end

endmodule // siem_smb_master

// ---- logic/siem_expander_manager.sv ----
// expander manager: configures, updates and polls smbus i/o expanders
`timescale 1ns/1ps
// Contract
// - hot-plug expanders write default outputs regs 2,3
// - configuration sequence writes zero to regs 4,5; update, read and reload jobs skip them
// - then write direction to regs 6,7
// - sequence ends reading reg 0 then 1
// - expander two skips reg 3, upper all inputs
// - expander four: all sixteen pins outputs
// - enabled expander out of step triggers transaction
// - hot-reset default changes resync expander outputs
// - output writes at most once per 40 ms
// - interrupt causes input read, once per 40 ms
// - round-robin arbitration across expanders
// - transaction errors recorded in status bits
// - select picks expander; data shows its view
// - reload issues write and read, refreshes view
// - test mode drives outputs from debug data
// - expander zero halves: low inputs, high outputs
// - configure expanders when normal operation begins
// - fundamental reset entry leaves outputs untouched
// - output data captured when transaction starts
// - address change reconfigures; disabled outputs negated
// - no transaction before eeprom load completes
// - led outputs active low, hot-plug uninverted
module siem_expander_manager #(
	parameter int NUM_EXP = siem_pkg::NUM_EXP,
	parameter int UPDATE_CYCLES = siem_pkg::UPDATE_CYCLES,
	parameter int QTR_CYCLES = siem_pkg::SMB_QTR_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic eeprom_done_i,
	input wire logic normal_op_i,
	input wire logic [NUM_EXP-1:0] exp_enable_i,
	input wire logic [NUM_EXP*siem_pkg::ADDR_W-1:0] expander_address_field_i,
	input wire logic [NUM_EXP*siem_pkg::EXP_W-1:0] core_out_i,
	input wire logic [NUM_EXP*siem_pkg::EXP_W-1:0] port_off_i,
	input wire logic [NUM_EXP-1:0] exp_int_n_i,
	input wire siem_pkg::siem_debug_t expander_debug_reg_i,
	input wire siem_pkg::siem_status_t status_clr_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic [15:0] expander_view_data_o,
	output siem_pkg::siem_status_t smbus_status_reg_o,
	output logic [NUM_EXP*siem_pkg::EXP_W-1:0] exp_inputs_o,
	output logic busy_o,
	output logic scl_o,
	output logic scl_oe_n_o,
	output logic sda_o,
	output logic sda_oe_n_o
);
	localparam int EW = $clog2(NUM_EXP);
	localparam int TW = $clog2(UPDATE_CYCLES + 1);
	localparam int XW = siem_pkg::EXP_W;
	localparam int AW = siem_pkg::ADDR_W;

	// ******************************
	// reset release and pin synchronisers
	// ******************************
	logic rst_meta, rst_n;
	logic [NUM_EXP-1:0] int_meta, int_sync;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			int_meta <= '1;
			int_sync <= '1;
		end else begin
			int_meta <= exp_int_n_i;
			int_sync <= int_meta;
		end
	end

	// ******************************
	// per-expander state
	// ******************************
	logic [15:0] shadow [NUM_EXP];
	logic [15:0] in_data [NUM_EXP];
	logic [15:0] want [NUM_EXP];
	logic [TW-1:0] wr_cnt [NUM_EXP];
	logic [TW-1:0] rd_cnt [NUM_EXP];
	logic [NUM_EXP*AW-1:0] addr_q;
	logic [NUM_EXP-1:0] cfg_pend, reload_pend, configured;
	logic [NUM_EXP-1:0] addr_chg, mismatch, wr_need, rd_need, req;
	logic [15:0] test_data;
	logic run, run_q;

	// eeprom load owns the shared bus until it is done
	assign run = eeprom_done_i && normal_op_i;
	wire run_rise = run && !run_q;
	wire [EW-1:0] sel = expander_debug_reg_i.sel[EW-1:0];

	for (genvar e = 0; e < NUM_EXP; e++) begin : g_exp
		wire [15:0] core_bits = core_out_i[e*XW +: XW] & ~port_off_i[e*XW +: XW];
		// led lines sink current to light, hot-plug lines pass straight
		wire [15:0] core_drv = (e == siem_pkg::EXP_LED) ? ~core_bits : core_bits;
		wire test_sel = expander_debug_reg_i.test_mode && (sel == EW'(e));
		// outputs sit in the high nibble of each half on hot-plug parts
		assign want[e] = (test_sel ? test_data : core_drv) & siem_pkg::out_mask_of(e);
		assign addr_chg[e] = addr_q[e*AW +: AW] != expander_address_field_i[e*AW +: AW];
		assign mismatch[e] = want[e] != shadow[e];
		assign wr_need[e] = configured[e] && mismatch[e] && (wr_cnt[e] == '0);
		assign rd_need[e] = configured[e] && !int_sync[e] && (rd_cnt[e] == '0);
		assign req[e] = run && exp_enable_i[e] &&
			(cfg_pend[e] || reload_pend[e] || wr_need[e] || rd_need[e]);
		assign exp_inputs_o[e*XW +: XW] = in_data[e];
	end

	// ******************************
	// round-robin grant
	// ******************************
	logic [EW-1:0] rr;
	logic [EW-1:0] gnt_idx;
	logic gnt_valid;

	always_comb begin
		int i;
		i = 0;
		gnt_valid = 1'b0;
		gnt_idx = '0;
		for (int k = NUM_EXP - 1; k >= 0; k--) begin
			i = (int'(rr) + k) % NUM_EXP;
			if (req[i]) begin
				gnt_valid = 1'b1;
				gnt_idx = EW'(i);
			end
		end
	end

	wire [7:0] cfg_mask = (gnt_idx == EW'(siem_pkg::EXP_PWRGOOD)) ?
		siem_pkg::JOB_CFG_NO_UPPER_DEF : siem_pkg::JOB_CFG;
	wire [7:0] svc_mask = (wr_need[gnt_idx] ? siem_pkg::JOB_UPDATE : siem_pkg::JOB_NONE) |
		(rd_need[gnt_idx] ? siem_pkg::JOB_READ : siem_pkg::JOB_NONE);
	wire [7:0] job_mask = cfg_pend[gnt_idx] ? cfg_mask :
		reload_pend[gnt_idx] ? siem_pkg::JOB_RELOAD : svc_mask;

	// ******************************
	// job sequencer
	// ******************************
	siem_pkg::siem_job_state_t jstate;
	logic [EW-1:0] cur;
	logic [7:0] cur_mask;
	logic cur_cfg;
	logic [2:0] step;
	logic [15:0] txn_out;
	logic job_ok;
	logic mreq_valid;
	siem_pkg::siem_req_t mreq;
	logic m_done, m_nack, m_lost;
	logic [7:0] m_rdata;

	wire job_start = (jstate == siem_pkg::J_IDLE) && gnt_valid;
	wire m_err = m_nack || m_lost;
	wire last_step = (step == siem_pkg::STEP_LAST);
	wire job_end = ((jstate == siem_pkg::J_ISSUE) && !cur_mask[step] && last_step) ||
		((jstate == siem_pkg::J_WAIT) && m_done && (m_err || last_step));
	wire job_fail = (jstate == siem_pkg::J_WAIT) && m_done && m_err;
	wire step_rd = step >= siem_pkg::STEP_FIRST_READ;
	wire [15:0] cur_dir = siem_pkg::dir_of(int'(cur));

	// steps 0..7 reach registers 2,3,4,5,6,7,0,1 in that order
	logic [7:0] step_data;
	always_comb begin
		case (step)
			3'h0: step_data = txn_out[7:0];
			3'h1: step_data = txn_out[15:8];
			3'h2: step_data = siem_pkg::NO_INVERT;
			3'h3: step_data = siem_pkg::NO_INVERT;
			3'h4: step_data = cur_dir[7:0];
			3'h5: step_data = cur_dir[15:8];
			default: step_data = siem_pkg::NO_INVERT;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			jstate <= siem_pkg::J_IDLE;
			cur <= '0;
			cur_mask <= siem_pkg::JOB_NONE;
			cur_cfg <= 1'b0;
			step <= 3'h0;
			txn_out <= 16'h0000;
			job_ok <= 1'b0;
			rr <= '0;
			mreq_valid <= 1'b0;
			mreq <= '0;
		end else begin
			mreq_valid <= 1'b0;
			case (jstate)
				siem_pkg::J_IDLE: if (job_start) begin
					cur <= gnt_idx;
					cur_mask <= job_mask;
					cur_cfg <= cfg_pend[gnt_idx];
					// frozen here so later core changes cannot glitch this write
					txn_out <= want[gnt_idx];
					step <= 3'h0;
					job_ok <= 1'b1;
					rr <= (int'(gnt_idx) == NUM_EXP - 1) ? '0 : gnt_idx + 1'b1;
					jstate <= siem_pkg::J_ISSUE;
				end
				siem_pkg::J_ISSUE: if (cur_mask[step]) begin
					mreq_valid <= 1'b1;
					mreq.rd <= step_rd;
					mreq.addr <= expander_address_field_i[int'(cur)*AW +: AW];
					mreq.cmd <= {5'h00, step + siem_pkg::REG_OFFSET};
					mreq.wdata <= step_data;
					jstate <= siem_pkg::J_WAIT;
				end else if (last_step) begin
					jstate <= siem_pkg::J_IDLE;
				end else begin
					step <= step + 3'h1;
				end
				siem_pkg::J_WAIT: if (m_done) begin
					if (m_err || last_step) begin
						job_ok <= !m_err;
						jstate <= siem_pkg::J_IDLE;
					end else begin
						step <= step + 3'h1;
						jstate <= siem_pkg::J_ISSUE;
					end
				end
				default: jstate <= siem_pkg::J_IDLE;
			endcase
		end
	end

	wire job_done_ok = job_end && !job_fail && job_ok;

	// ******************************
	// pending flags, timers and shadows; a new request wins over completion
	// ******************************
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			addr_q <= '0;
			cfg_pend <= '0;
			reload_pend <= '0;
			configured <= '0;
			test_data <= 16'h0000;
			for (int e = 0; e < NUM_EXP; e++) begin
				shadow[e] <= 16'h0000;
				in_data[e] <= 16'h0000;
				wr_cnt[e] <= '0;
				rd_cnt[e] <= '0;
			end
		end else begin
			run_q <= run;
			addr_q <= expander_address_field_i;
			if (expander_debug_reg_i.wr)
				test_data <= expander_debug_reg_i.wdata;
			for (int e = 0; e < NUM_EXP; e++) begin
				if (job_end && (int'(cur) == e)) begin
					if (cur_cfg)
						cfg_pend[e] <= 1'b0;
					else
						reload_pend[e] <= 1'b0;
					if (job_done_ok && cur_cfg)
						configured[e] <= 1'b1;
					if (job_done_ok && (cur_mask[1:0] != 2'h0))
						shadow[e] <= txn_out;
				end
				// leaving normal operation starts nothing, so pins keep their state
				if (run_rise && exp_enable_i[e])
					cfg_pend[e] <= 1'b1;
				if (addr_chg[e]) begin
					cfg_pend[e] <= 1'b1;
					configured[e] <= 1'b0;
				end
				if (expander_debug_reg_i.reload && (int'(sel) == e))
					reload_pend[e] <= 1'b1;
				if (job_start && (int'(gnt_idx) == e) && (job_mask[1:0] != 2'h0))
					wr_cnt[e] <= TW'(UPDATE_CYCLES);
				else if (wr_cnt[e] != '0)
					wr_cnt[e] <= wr_cnt[e] - 1'b1;
				if (job_start && (int'(gnt_idx) == e) && (job_mask[7:6] != 2'h0))
					rd_cnt[e] <= TW'(UPDATE_CYCLES);
				else if (rd_cnt[e] != '0)
					rd_cnt[e] <= rd_cnt[e] - 1'b1;
				if ((jstate == siem_pkg::J_WAIT) && m_done && !m_err && step_rd &&
					(int'(cur) == e)) begin
					if (step == siem_pkg::STEP_FIRST_READ)
						in_data[e][7:0] <= m_rdata;
					else
						in_data[e][15:8] <= m_rdata;
				end
			end
		end
	end

	// ******************************
	// status, debug view and busy
	// ******************************
	wire [15:0] sel_mask = siem_pkg::out_mask_of(int'(sel));
	wire [15:0] sel_out = expander_debug_reg_i.test_mode ? (test_data & sel_mask) : shadow[sel];

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			smbus_status_reg_o <= '0;
			expander_view_data_o <= 16'h0000;
			busy_o <= 1'b0;
		end else begin
			smbus_status_reg_o <= smbus_status_reg_o & ~status_clr_i;
			if (job_fail && m_nack)
				smbus_status_reg_o.nack <= 1'b1;
			if (job_fail && m_lost)
				smbus_status_reg_o.lost_arb <= 1'b1;
			expander_view_data_o <= (in_data[sel] & ~sel_mask) | sel_out;
			busy_o <= (jstate != siem_pkg::J_IDLE) || job_start;
		end
	end

	siem_smb_master #(
		.QTR_CYCLES(QTR_CYCLES)
	) u_master (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.req_valid_i(mreq_valid),
		.req_i(mreq),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.done_o(m_done),
		.nack_o(m_nack),
		.lost_o(m_lost),
		.rdata_o(m_rdata),
		.scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n_o),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o)
	);

endmodule // siem_expander_manager

// ---- verif/siem_expander_manager_monitor.sv ----
// port-level assertions for the expander manager
`timescale 1ns/1ps
module siem_expander_manager_monitor #(
	parameter int NUM_EXP = siem_pkg::NUM_EXP,
	parameter int UPDATE_CYCLES = siem_pkg::UPDATE_CYCLES,
	parameter int QTR_CYCLES = siem_pkg::SMB_QTR_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic eeprom_done_i,
	input wire logic normal_op_i,
	input wire siem_pkg::siem_debug_t expander_debug_reg_i,
	input wire siem_pkg::siem_status_t status_clr_i,
	input wire logic [15:0] expander_view_data_o,
	input wire siem_pkg::siem_status_t smbus_status_reg_o,
	input wire logic [NUM_EXP*siem_pkg::EXP_W-1:0] exp_inputs_o,
	input wire logic busy_o,
	input wire logic scl_oe_n_o,
	input wire logic sda_oe_n_o
);
	// one transaction, stop to stop, with margin
	localparam int BUSY_MAX = 1400 * QTR_CYCLES + 100;
	int busy_len;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_len <= 0;
		end else begin
			busy_len <= busy_o && !(scl_oe_n_o && $rose(sda_oe_n_o)) ? busy_len + 1 : 0;
		end
	end
	// ******************************
	// bus framing and status
	// ******************************
	sequence s_start;
		scl_oe_n_o && $past(scl_oe_n_o) && $fell(sda_oe_n_o);
	endsequence
	sequence s_quiet;
		!busy_o [*3];
	endsequence
	a_run_gates_job: assert property (!(eeprom_done_i && normal_op_i) |=> !$rose(busy_o))
		else $error("job started while not running");
	a_quiet_lines: assert property (s_quiet |-> scl_oe_n_o && sda_oe_n_o)
		else $error("bus driven outside a job");
	a_start_in_job: assert property (s_start |-> busy_o)
		else $error("start condition outside a job");
	a_busy_bounded: assert property (busy_len < BUSY_MAX)
		else $error("job runs too long");
	a_nack_sticky: assert property (smbus_status_reg_o.nack && !status_clr_i.nack
		|=> smbus_status_reg_o.nack) else $error("nack bit lost");
	a_lost_sticky: assert property (smbus_status_reg_o.lost_arb && !status_clr_i.lost_arb
		|=> smbus_status_reg_o.lost_arb) else $error("lost bit lost");
	a_error_in_job: assert property ($rose(smbus_status_reg_o.nack) |-> $past(busy_o))
		else $error("nack set outside a job");
	a_nack_clears: assert property (status_clr_i.nack && !busy_o
		|=> !smbus_status_reg_o.nack) else $error("nack not cleared");
	a_view_inputs: assert property ($past(expander_debug_reg_i.sel) == 3'h1 && $stable(exp_inputs_o)
		|-> (expander_view_data_o & 16'h0F0F) == (exp_inputs_o[16+:16] & 16'h0F0F))
		else $error("view differs from inputs");
endmodule // siem_expander_manager_monitor
bind siem_expander_manager siem_expander_manager_monitor #(.NUM_EXP(NUM_EXP),
	.UPDATE_CYCLES(UPDATE_CYCLES), .QTR_CYCLES(QTR_CYCLES)) u_monitor (.*);

// ---- verif/siem_exp_model.sv ----
// behavioural model of five smbus 16-bit expanders on one bus
`timescale 1ns/1ps
module siem_exp_model #(
	parameter logic [34:0] ADDRS = 35'h0
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [79:0] pins_i,
	output logic sda_oe_n_o,
	output logic [4:0] int_n_o
);
	logic [23:0] log_q[$];
	logic [7:0] regs[5][8];
	logic [15:0] seen[5];
	logic [7:0] sh, ptr, tx;
	logic [6:0] ad;
	logic rd;
	int n, ph, e;
	// ******************************
	// byte engine
	// ******************************
	initial begin
		sda_oe_n_o = 1'b1;
		ph = 3;
		foreach (regs[i, j]) regs[i][j] = j > 5 ? 8'hFF : 8'h00;
		foreach (seen[i]) seen[i] = 16'h0;
	end
	always @(negedge sda_i) if (scl_i) begin n = 0; ph = 0; end
	always @(posedge sda_i) if (scl_i) ph = 3;
	always @(posedge scl_i) if (ph != 3) begin sh = {sh[6:0], sda_i}; n++; end
	always @(negedge scl_i) begin
		if (ph == 4) begin
			sda_oe_n_o = n < 8 ? tx[7-n] : 1'b1;
		end else if (ph != 3 && n == 8) begin
			if (ph == 0) begin
				e = -1;
				for (int i = 0; i < 5; i++) if (ADDRS[i*7+:7] == sh[7:1]) e = i;
				rd = sh[0];
				ad = sh[7:1];
				if (e < 0) ph = 3;
				else sda_oe_n_o = 1'b0;
			end else begin
				if (ph == 1) ptr = sh;
				else begin regs[e][ptr[2:0]] = sh; log_q.push_back({1'b0, ad, ptr, sh}); end
				sda_oe_n_o = 1'b0;
			end
		end else if (ph != 3 && n == 9) begin
			n = 0;
			if (ph == 0 && rd) begin
				tx = ptr[0] ? pins_i[e*16+8+:8] : pins_i[e*16+:8];
				if (ptr[0]) seen[e][15:8] = tx; else seen[e][7:0] = tx;
				log_q.push_back({1'b1, ad, ptr, tx});
				ph = 4;
				sda_oe_n_o = tx[7];
			end else begin
				sda_oe_n_o = 1'b1;
				if (ph < 2) ph++;
			end
		end
	end
	// input pins away from last read value raise the interrupt
	always_comb for (int i = 0; i < 5; i++)
		int_n_o[i] = ((pins_i[i*16+:16] ^ seen[i]) & {regs[i][7], regs[i][6]}) == 16'h0;
endmodule // siem_exp_model

// ---- verif/siem_expander_manager_tb.sv ----
// self-checking bench for the expander manager
`timescale 1ns/1ps
module siem_expander_manager_tb;
	localparam int UPD = 1000;
	localparam logic [34:0] ADRS = {7'h24, 7'h23, 7'h22, 7'h21, 7'h20};
	logic clk_sys_i, busy, scl_d, sda_d, scl_oe_n, sda_oe_n, m_oe_n, jam = 0;
	logic reset_n_i = 0, eeprom_done_i = 0, normal_op_i = 0;
	logic [34:0] addr = ADRS;
	logic [79:0] core_out_i = 80'h0, port_off_i = 80'h0, pins = 80'h0, ins;
	siem_pkg::siem_debug_t dbg = '0;
	siem_pkg::siem_status_t clr = '0, sts;
	logic [15:0] view;
	logic [4:0] int_n;
	wire scl = scl_oe_n | scl_d;
	wire sda = (sda_oe_n | sda_d) & m_oe_n & !jam;
	int bad_count = 0, compares = 0, cyc = 0;
	siem_expander_manager #(.UPDATE_CYCLES(UPD), .QTR_CYCLES(2)) dut (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .eeprom_done_i(eeprom_done_i), .normal_op_i(normal_op_i),
		.exp_enable_i(5'h1F), .expander_address_field_i(addr), .core_out_i(core_out_i),
		.port_off_i(port_off_i), .exp_int_n_i(int_n), .expander_debug_reg_i(dbg),
		.status_clr_i(clr), .scl_i(scl), .sda_i(sda), .expander_view_data_o(view),
		.smbus_status_reg_o(sts), .exp_inputs_o(ins), .busy_o(busy), .scl_o(scl_d),
		.scl_oe_n_o(scl_oe_n), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n));
	siem_exp_model #(.ADDRS(ADRS)) mdl (.scl_i(scl), .sda_i(sda), .pins_i(pins),
		.sda_oe_n_o(m_oe_n), .int_n_o(int_n));
	initial begin clk_sys_i = 0; forever #5 clk_sys_i = ~clk_sys_i; end
	always @(posedge clk_sys_i) cyc++;
	// ******************************
	// helpers
	// ******************************
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic cmp(input string w, input logic [15:0] x, input logic [15:0] g);
		compares++;
		if (g !== x) begin bad_count++; $display("unexpected %s expected %h seen %h", w, x, g); end
	endtask
	task automatic settle();
		int q;
		q = 0;
		for (int k = 0; k < 40000 && q < UPD + 200; k++) begin step(1); q = busy === 1'b0 ? q + 1 : 0; end
		if (q < UPD + 200) begin bad_count++; $display("unexpected idle expected 1 seen 0"); finish_test(); end
	endtask
	task automatic wait_log(input int n);
		for (int k = 0; k < 20000 && mdl.log_q.size() < n; k++) step(1);
		if (mdl.log_q.size() < n) begin bad_count++; $display("unexpected log expected %0d seen %0d",
			n, mdl.log_q.size()); finish_test(); end
	endtask
	// direction per expander, 1 = input
	function automatic logic [15:0] dr(input int e);
		return e == 4 ? 16'h0000 : e == 2 ? 16'hFF0F : 16'h0F0F;
	endfunction
	function automatic logic [15:0] ov(input int e);
		logic [15:0] v;
		v = core_out_i[e*16+:16] & ~port_off_i[e*16+:16];
		return e == 4 ? ~v : v;
	endfunction
	task automatic chk_out(input int e);
		cmp("outputs", ov(e) & ~dr(e), {mdl.regs[e][3], mdl.regs[e][2]} & ~dr(e));
	endtask
	task automatic chk_seq(input int e, input int from, input logic [7:0] rg[$]);
		int k;
		logic [23:0] g;
		logic [15:0] x, m;
		k = 0;
		for (int i = from; i < mdl.log_q.size(); i++) begin
			g = mdl.log_q[i];
			if (g[22:16] == ADRS[e*7+:7] && k < rg.size()) begin
				x = rg[k] > 5 ? dr(e) : rg[k] > 3 ? 16'h0 : ov(e);
				m = rg[k] < 2 ? 16'h0 : rg[k] > 3 ? 16'hFFFF : ~dr(e);
				x = rg[k][0] ? x >> 8 : x;
				m = rg[k][0] ? m >> 8 : m;
				cmp("access", {7'h0, rg[k] < 8'h2, rg[k]}, {7'h0, g[23], g[15:8]});
				cmp("data", {8'h0, x[7:0] & m[7:0]}, {8'h0, g[7:0] & m[7:0]});
				k++;
			end
		end
		cmp("count", 16'(rg.size()), 16'(k));
	endtask
	// ******************************
	// scenarios
	// ******************************
	initial begin
		int n, t;
		void'($urandom(32'h5847E24D));
		step(12);
		reset_n_i = 1;
		step(3);
		core_out_i = {$urandom(), $urandom(), 16'($urandom())};
		normal_op_i = 1;
		step(400);
		cmp("early", 16'h0, 16'(mdl.log_q.size()));
		eeprom_done_i = 1;
		settle();
		for (int e = 0; e < 5; e++) begin
			if (e == 2) chk_seq(e, 0, '{2, 4, 5, 6, 7, 0, 1});
			else chk_seq(e, 0, '{2, 3, 4, 5, 6, 7, 0, 1});
		end
		$display("test configure done");
		n = mdl.log_q.size();
		core_out_i[7:4] = ~core_out_i[7:4];
		wait_log(n + 1);
		t = cyc;
		core_out_i[7:4] = ~core_out_i[7:4];
		wait_log(n + 3);
		cmp("spacing", 16'h1, 16'(cyc - t >= UPD));
		settle();
		chk_out(0);
		$display("test update done");
		core_out_i = ~core_out_i;
		port_off_i = {$urandom(), $urandom(), 16'($urandom())};
		settle();
		for (int e = 0; e < 5; e++) chk_out(e);
		$display("test resync done");
		pins[16+:16] = pins[16+:16] ^ {4'h0, 4'($urandom()), 4'h0, 4'($urandom()) | 4'h1};
		step(1);
		cmp("int", 16'h0, 16'(int_n[1]));
		settle();
		cmp("inputs", pins[16+:16] & 16'h0F0F, ins[16+:16] & 16'h0F0F);
		cmp("int clear", 16'h1, 16'(int_n[1]));
		$display("test interrupt done");
		dbg.sel = 3'h1;
		n = mdl.log_q.size();
		dbg.reload = 1;
		step(1);
		dbg.reload = 0;
		settle();
		chk_seq(1, n, '{2, 3, 0, 1});
		cmp("view", pins[16+:16] & 16'h0F0F, view & 16'h0F0F);
		dbg.sel = 3'h4;
		dbg.test_mode = 1;
		dbg.wdata = 16'($urandom());
		dbg.wr = 1;
		step(1);
		dbg.wr = 0;
		settle();
		cmp("test out", dbg.wdata, {mdl.regs[4][3], mdl.regs[4][2]});
		cmp("test view", dbg.wdata, view);
		dbg.test_mode = 0;
		settle();
		chk_out(4);
		$display("test debug done");
		jam = 1;
		dbg.reload = 1;
		step(1);
		dbg.reload = 0;
		settle();
		jam = 0;
		cmp("lost", 16'h1, 16'(sts.lost_arb));
		addr[21+:7] = 7'h50;
		settle();
		cmp("nack", 16'h1, 16'(sts.nack));
		clr.nack = 1;
		step(1);
		clr.nack = 0;
		step(2);
		cmp("nack clear", 16'h0, 16'(sts.nack));
		n = mdl.log_q.size();
		addr = ADRS;
		settle();
		chk_seq(3, n, '{2, 3, 4, 5, 6, 7, 0, 1});
		$display("test error done");
		finish_test();
	end
endmodule // siem_expander_manager_tb
